// [logic/hsq_pkg.sv]
// package: register map, reset values, state and carrier types for the haptic sequencer
package hsq_pkg;

  // ----------------------------------------------------------------
  // register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL        = 8'h01;
  localparam logic [7:0] IDX_TICK        = 8'h02;
  localparam logic [7:0] IDX_STATUS      = 8'h03;
  localparam logic [7:0] IDX_SLOT_ID     = 8'h08;
  localparam logic [7:0] IDX_SLOT_REP_LO = 8'h17;
  localparam logic [7:0] IDX_SLOT_REP_HI = 8'h18;
  localparam logic [7:0] IDX_MAIN_REP    = 8'h19;
  localparam logic [7:0] IDX_OD_ADJ      = 8'h1a;
  localparam logic [7:0] IDX_PS_ADJ      = 8'h1b;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         CTRL_GO_BIT     = 0;
  localparam int         CTRL_CLOSED_BIT = 1;
  localparam logic [2:0] RST_MAIN_REP    = 3'h0;
  localparam logic [7:0] RST_OD_ADJ      = 8'h00;
  localparam logic [7:0] RST_PS_ADJ      = 8'h00;
  localparam logic [7:0] RST_TICK        = 8'h13;
  localparam logic [2:0] INFINITE_REP    = 3'h7;
  localparam logic [2:0] LAST_SLOT       = 3'h7;
  localparam logic [7:0] VOLT_MIN        = 8'h80;

  typedef enum logic [1:0] {HSQ_IDLE, HSQ_SCAN, HSQ_LOAD, HSQ_RUN} hsq_state_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0] id;
    logic [3:0] seg;
  } hsq_lib_req_t;

  typedef struct packed {
    logic [7:0] volt;
    logic [7:0] len;
    logic       last;
  } hsq_lib_seg_t;

  typedef struct packed {
    logic [2:0]      sync;
    logic            trig_lvl;
    logic            wr_pend;
    logic [7:0]      idx;
    logic [31:0]     rdata;
    logic [2:0]      sequence_repeat_count;
    logic [7:0]      overdrive_time_adjust;
    logic [7:0]      positive_sustain_adjust;
    logic [7:0]      playback_tick_period;
    logic            closed_loop;
    logic [7:0][6:0] ids;
    logic [7:0][1:0] slot_repeat_count;
    hsq_state_t      st;
    logic [2:0]      slot;
    logic [2:0]      pass;
    logic [2:0]      pass_lim;
    logic [1:0]      rep;
    logic [3:0]      seg;
    logic [7:0]      maxv;
    logic [7:0]      tick;
    logic [8:0]      dur;
    logic [7:0]      volt;
  } hsq_regs_t;

endpackage

// [logic/hsq_top.sv]
// module: haptic sequencer loop control with signed segment time offsets, AHB-Lite slave
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module hsq_top (
  // clock and reset
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_in,
  // ahb-lite slave
  input  wire logic                  hsel_in,
  input  wire logic [31:0]           haddr_in,
  input  wire logic [1:0]            htrans_in,
  input  wire logic                  hwrite_in,
  input  wire logic [2:0]            hsize_in,
  input  wire logic [31:0]           hwdata_in,
  input  wire logic                  hready_in,
  output logic      [31:0]           hrdata_out,
  output logic                       hreadyout_out,
  output logic                       hresp_out,
  // trigger pin
  input  wire logic                  trig_pin_in,
  // waveform library
  output hsq_pkg::hsq_lib_req_t      lib_req_out,
  input  wire hsq_pkg::hsq_lib_seg_t lib_seg_in,
  // drive
  output logic      [7:0]            drive_volt_out,
  output logic                       busy_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  hsq_pkg::hsq_regs_t s;
  hsq_pkg::hsq_regs_t next_s;

  logic              addr_ok;
  logic              sel;
  logic              trig_evt;
  logic              od_seg;
  logic              ps_seg;
  logic signed [9:0] seg_sum;
  logic              seg_done;
  logic              start_req;
  logic              stop_req;
  logic              wr_ctrl;

  function automatic logic [31:0] rd_val(input hsq_pkg::hsq_regs_t r, input logic [7:0] i);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (i[7:3] == hsq_pkg::IDX_SLOT_ID[7:3])
      v[6:0] = r.ids[i[2:0]];
    else
      case (i)
        hsq_pkg::IDX_CTRL:
        begin
          v[hsq_pkg::CTRL_GO_BIT]     = (r.st != hsq_pkg::HSQ_IDLE);
          v[hsq_pkg::CTRL_CLOSED_BIT] = r.closed_loop;
        end
        hsq_pkg::IDX_TICK:        v[7:0] = r.playback_tick_period;
        hsq_pkg::IDX_STATUS:
          v[11:0] = {r.rep, r.pass, r.slot, 3'h0, r.st != hsq_pkg::HSQ_IDLE};
        hsq_pkg::IDX_SLOT_REP_LO: v[7:0] = r.slot_repeat_count[3:0];
        hsq_pkg::IDX_SLOT_REP_HI: v[7:0] = r.slot_repeat_count[7:4];
        hsq_pkg::IDX_MAIN_REP:    v[2:0] = r.sequence_repeat_count;
        hsq_pkg::IDX_OD_ADJ:      v[7:0] = r.overdrive_time_adjust;
        hsq_pkg::IDX_PS_ADJ:      v[7:0] = r.positive_sustain_adjust;
        default:                  v = 32'h0000_0000;
      endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // segment classification and duration
  // ----------------------------------------------------------------
  // overdrive is the peak
  assign od_seg = ($signed(lib_seg_in.volt) == $signed(s.maxv));
  assign ps_seg = !od_seg && ($signed(lib_seg_in.volt) > $signed(8'sh00));

  always_comb
  begin
    seg_sum = $signed({2'b00, lib_seg_in.len});
    // signed overdrive offset, open loop only
    if (od_seg && !s.closed_loop)
      seg_sum = $signed({2'b00, lib_seg_in.len})
              + $signed({{2{s.overdrive_time_adjust[7]}}, s.overdrive_time_adjust});
    // sustain offset holds in either loop mode
    else if (ps_seg)
      seg_sum = $signed({2'b00, lib_seg_in.len})
              + $signed({{2{s.positive_sustain_adjust[7]}}, s.positive_sustain_adjust});
  end

  assign addr_ok  = (haddr_in[31:10] == 22'h00_0000);
  assign sel      = hsel_in && htrans_in[1] && hready_in;
  // only the agreeing second and third stages decide the level
  assign trig_evt = (s.sync[1] == s.sync[2]) && s.sync[2] && !s.trig_lvl;
  assign wr_ctrl  = s.wr_pend && (s.idx == hsq_pkg::IDX_CTRL);
  assign stop_req = (trig_evt && s.st != hsq_pkg::HSQ_IDLE)
                 || (wr_ctrl && !hwdata_in[hsq_pkg::CTRL_GO_BIT]);
  assign start_req = (trig_evt && s.st == hsq_pkg::HSQ_IDLE)
                  || (wr_ctrl && hwdata_in[hsq_pkg::CTRL_GO_BIT]);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s   = s;
    seg_done = 1'b0;
    next_s.sync = {s.sync[1:0], trig_pin_in};
    if (s.sync[1] == s.sync[2])
      next_s.trig_lvl = s.sync[2];

    // register writes in the data phase
    if (s.wr_pend)
    begin
      if (s.idx[7:3] == hsq_pkg::IDX_SLOT_ID[7:3])
        next_s.ids[s.idx[2:0]] = hwdata_in[6:0];
      else
        case (s.idx)
          hsq_pkg::IDX_CTRL:        next_s.closed_loop = hwdata_in[hsq_pkg::CTRL_CLOSED_BIT];
          hsq_pkg::IDX_TICK:        next_s.playback_tick_period = hwdata_in[7:0];
          hsq_pkg::IDX_SLOT_REP_LO: next_s.slot_repeat_count[3:0] = hwdata_in[7:0];
          hsq_pkg::IDX_SLOT_REP_HI: next_s.slot_repeat_count[7:4] = hwdata_in[7:0];
          hsq_pkg::IDX_MAIN_REP:    next_s.sequence_repeat_count = hwdata_in[2:0];
          hsq_pkg::IDX_OD_ADJ:      next_s.overdrive_time_adjust = hwdata_in[7:0];
          hsq_pkg::IDX_PS_ADJ:      next_s.positive_sustain_adjust = hwdata_in[7:0];
          default:                  next_s.wr_pend = 1'b0;
        endcase
    end

    // address phase capture; read data is ready for the data phase
    next_s.wr_pend = sel && hwrite_in && addr_ok;
    next_s.idx     = haddr_in[9:2];
    if (sel && !hwrite_in)
      next_s.rdata = addr_ok ? rd_val(s, haddr_in[9:2]) : 32'h0000_0000;

    unique case (s.st)
      hsq_pkg::HSQ_IDLE:
        next_s.volt = 8'h00;
      hsq_pkg::HSQ_SCAN:
      begin
        if ($signed(lib_seg_in.volt) > $signed(s.maxv))
          next_s.maxv = lib_seg_in.volt;
        next_s.seg = s.seg + 4'h1;
        if (lib_seg_in.last)
        begin
          next_s.seg = 4'h0;
          next_s.st  = hsq_pkg::HSQ_LOAD;
        end
      end
      hsq_pkg::HSQ_LOAD:
      begin
        if (seg_sum > $signed(10'sh000))
        begin
          next_s.dur  = seg_sum[8:0];
          next_s.volt = lib_seg_in.volt;
          next_s.tick = 8'h00;
          next_s.st   = hsq_pkg::HSQ_RUN;
        end
        else
          seg_done = 1'b1;
      end
      hsq_pkg::HSQ_RUN:
      begin
        // one duration unit per tick
        if (s.tick == s.playback_tick_period)
        begin
          next_s.tick = 8'h00;
          if (s.dur == 9'h001)
            seg_done = 1'b1;
          else
            next_s.dur = s.dur - 9'h001;
        end
        else
          next_s.tick = s.tick + 8'h01;
      end
    endcase

    if (seg_done)
    begin
      next_s.volt = 8'h00;
      next_s.st   = hsq_pkg::HSQ_LOAD;
      if (!lib_seg_in.last)
        next_s.seg = s.seg + 4'h1;
      else if (s.rep != s.slot_repeat_count[s.slot])
      begin
        next_s.rep = s.rep + 2'h1;
        next_s.seg = 4'h0;
      end
      else
      begin
        next_s.rep  = 2'h0;
        next_s.seg  = 4'h0;
        next_s.maxv = hsq_pkg::VOLT_MIN;
        next_s.st   = hsq_pkg::HSQ_SCAN;
        if (s.slot != hsq_pkg::LAST_SLOT && s.ids[s.slot + 3'h1] != 7'h00)
          next_s.slot = s.slot + 3'h1;
        else if (s.pass_lim == hsq_pkg::INFINITE_REP || s.pass != s.pass_lim)
        begin
          next_s.slot = 3'h0;
          if (s.pass_lim != hsq_pkg::INFINITE_REP)
            next_s.pass = s.pass + 3'h1;
        end
        else
          next_s.st = hsq_pkg::HSQ_IDLE;
      end
    end

    if (stop_req)
    begin
      next_s.st   = hsq_pkg::HSQ_IDLE;
      next_s.volt = 8'h00;
    end
    // a start in the finishing cycle still counts
    else if (start_req && next_s.st == hsq_pkg::HSQ_IDLE && s.ids[0] != 7'h00)
    begin
      next_s.st       = hsq_pkg::HSQ_SCAN;
      next_s.slot     = 3'h0;
      next_s.pass     = 3'h0;
      next_s.rep      = 2'h0;
      next_s.seg      = 4'h0;
      next_s.maxv     = hsq_pkg::VOLT_MIN;
      next_s.pass_lim = s.sequence_repeat_count;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s                         <= '0;
      s.st                      <= hsq_pkg::HSQ_IDLE;
      s.sequence_repeat_count   <= hsq_pkg::RST_MAIN_REP;
      s.overdrive_time_adjust   <= hsq_pkg::RST_OD_ADJ;
      s.positive_sustain_adjust <= hsq_pkg::RST_PS_ADJ;
      s.playback_tick_period    <= hsq_pkg::RST_TICK;
      s.maxv                    <= hsq_pkg::VOLT_MIN;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // zero-wait slave: reads come from the flop filled in the address phase
  assign hrdata_out     = s.rdata;
  assign hreadyout_out  = 1'b1;
  assign hresp_out      = 1'b0;
  assign lib_req_out.id  = s.ids[s.slot];
  assign lib_req_out.seg = s.seg;
  assign drive_volt_out = s.volt;
  assign busy_out       = (s.st != hsq_pkg::HSQ_IDLE);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  property p_main_rep_write;
    s.wr_pend && s.idx == hsq_pkg::IDX_MAIN_REP |=> s.sequence_repeat_count == $past(hwdata_in[2:0]);
  endproperty
  a_main_rep_write: assert property (p_main_rep_write) else $error("main repeat not stored");

  property p_slot_nonzero;
    s.st == hsq_pkg::HSQ_LOAD || s.st == hsq_pkg::HSQ_RUN |-> s.ids[s.slot] != 7'h00;
  endproperty
  a_slot_nonzero: assert property (p_slot_nonzero) else $error("zero id played");

  property p_pass_bound;
    s.st != hsq_pkg::HSQ_IDLE && s.pass_lim != hsq_pkg::INFINITE_REP |-> s.pass <= s.pass_lim;
  endproperty
  a_pass_bound: assert property (p_pass_bound) else $error("too many passes");

  property p_infinite;
    s.st != hsq_pkg::HSQ_IDLE && s.pass_lim == hsq_pkg::INFINITE_REP && !stop_req
      |=> s.st != hsq_pkg::HSQ_IDLE;
  endproperty
  a_infinite: assert property (p_infinite) else $error("endless loop stopped");

  property p_od_dur;
    s.st == hsq_pkg::HSQ_LOAD && !s.closed_loop && od_seg && !stop_req && seg_sum > 10'sh000
      |=> s.dur == 9'($past(lib_seg_in.len) + $past(s.overdrive_time_adjust)
                      - {$past(s.overdrive_time_adjust[7]), 8'h00});
  endproperty
  a_od_dur: assert property (p_od_dur) else $error("overdrive duration wrong");

  property p_peak;
    s.st == hsq_pkg::HSQ_RUN |-> $signed(s.volt) <= $signed(s.maxv);
  endproperty
  a_peak: assert property (p_peak) else $error("segment above found peak");

  property p_closed_len;
    s.st == hsq_pkg::HSQ_LOAD && s.closed_loop && lib_seg_in.len != 8'h00 && !stop_req && !ps_seg
      |=> s.st == hsq_pkg::HSQ_RUN && s.dur == {1'b0, $past(lib_seg_in.len)};
  endproperty
  a_closed_len: assert property (p_closed_len) else $error("closed loop adjusted");

  property p_ps_dur;
    s.st == hsq_pkg::HSQ_LOAD && ps_seg && !stop_req && seg_sum > 10'sh000
      |=> s.dur == 9'($past(lib_seg_in.len) + $past(s.positive_sustain_adjust)
                      - {$past(s.positive_sustain_adjust[7]), 8'h00});
  endproperty
  a_ps_dur: assert property (p_ps_dur) else $error("sustain duration wrong");

  property p_slot_rep;
    s.st != hsq_pkg::HSQ_IDLE |-> s.rep <= s.slot_repeat_count[s.slot];
  endproperty
  a_slot_rep: assert property (p_slot_rep) else $error("slot repeat overrun");

  property p_clamp;
    s.st == hsq_pkg::HSQ_LOAD && seg_sum <= 10'sh000 |=> s.st != hsq_pkg::HSQ_RUN;
  endproperty
  a_clamp: assert property (p_clamp) else $error("non-positive segment ran");

  property p_tick_pace;
    s.st == hsq_pkg::HSQ_RUN && s.tick != s.playback_tick_period |=> s.dur == $past(s.dur);
  endproperty
  a_tick_pace: assert property (p_tick_pace) else $error("duration moved between ticks");

  property p_start_lim;
    s.st == hsq_pkg::HSQ_IDLE && next_s.st == hsq_pkg::HSQ_SCAN
      |=> s.pass_lim == $past(s.sequence_repeat_count);
  endproperty
  a_start_lim: assert property (p_start_lim) else $error("repeat count not latched");

  c_infinite: cover property (s.pass_lim == hsq_pkg::INFINITE_REP && seg_done && lib_seg_in.last
                              && s.slot == 3'h0 && s.st == hsq_pkg::HSQ_RUN);
  c_od_neg: cover property (s.st == hsq_pkg::HSQ_LOAD && od_seg && s.overdrive_time_adjust[7]);
  c_slot_rep: cover property (s.rep == 2'h3 && s.st == hsq_pkg::HSQ_RUN);
  c_trig_stop: cover property (trig_evt && s.st == hsq_pkg::HSQ_RUN);

endmodule
`default_nettype wire

// [tb/hsq_testbench.sv]
// testbench: register access and sequencer playback checks for the haptic sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                  ref_clk_in = 1'b0;
  logic                  rst_in     = 1'b1;
  logic                  hsel       = 1'b0;
  logic [31:0]           haddr      = 32'h0;
  logic [1:0]            htrans     = 2'h0;
  logic                  hwrite     = 1'b0;
  logic [31:0]           hwdata     = 32'h0;
  logic [31:0]           hrdata;
  logic                  hready;
  logic                  hresp;
  logic                  trig       = 1'b0;
  hsq_pkg::hsq_lib_req_t lib_req;
  hsq_pkg::hsq_lib_seg_t lib_seg;
  logic [7:0]            drive;
  logic                  busy;
  int                    failures   = 0;
  int                    compares   = 0;
  int                    od_cnt     = 0;
  int                    ps_cnt     = 0;
  int                    ng_cnt     = 0;
  logic [31:0]           rd;
  logic [7:0]            t_od [0:6] = '{8'h00, 8'h01, 8'hfd, 8'hfe, 8'h05, 8'h00, 8'h80};
  logic [7:0]            t_ps [0:6] = '{8'h00, 8'hff, 8'h02, 8'h00, 8'h02, 8'hfd, 8'h7f};

  always #2.5 ref_clk_in = ~ref_clk_in;

  hsq_top DUT (
    .ref_clk_in    (ref_clk_in),
    .rst_in        (rst_in),
    .hsel_in       (hsel),
    .haddr_in      (haddr),
    .htrans_in     (htrans),
    .hwrite_in     (hwrite),
    .hsize_in      (3'h2),
    .hwdata_in     (hwdata),
    .hready_in     (hready),
    .hrdata_out    (hrdata),
    .hreadyout_out (hready),
    .hresp_out     (hresp),
    .trig_pin_in   (trig),
    .lib_req_out   (lib_req),
    .lib_seg_in    (lib_seg),
    .drive_volt_out(drive),
    .busy_out      (busy)
  );

  // ----------------------------------------------------------------
  // library and drive monitor
  // ----------------------------------------------------------------
  // peak placed second so the overdrive search cannot just take segment zero
  always_comb
  begin
    case (lib_req.seg)
      4'h0:    lib_seg = {8'h20, 8'h03, 1'b0};
      4'h1:    lib_seg = {8'h40, 8'h02, 1'b0};
      default: lib_seg = {8'he0, 8'h02, 1'b1};
    endcase
  end

  // sampled on the falling edge so the flop output has settled
  always @(negedge ref_clk_in)
  begin
    if (drive === 8'h40)
      od_cnt++;
    if (drive === 8'h20)
      ps_cnt++;
    if (drive === 8'he0)
      ng_cnt++;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // single word transfer; read data taken at the edge ending the data phase
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge ref_clk_in);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge ref_clk_in);
    while (hready !== 1'b1) @(posedge ref_clk_in);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk_in);
    while (hready !== 1'b1) @(posedge ref_clk_in);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "response code");
  endtask

  task automatic wait_idle(input int limit);
    int n;
    n = 0;
    while (busy === 1'b1 && n < limit)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    chk({31'h0, busy}, 32'h0, "busy after stop");
  endtask

  task automatic pulse_trig;
    trig <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    trig <= 1'b0;
  endtask

  // plays: slot plays per pass times passes; tick period zero gives one clock per tick
  task automatic play(input logic [2:0] main, input logic [7:0] od, input logic [7:0] ps,
                      input logic cl, input int plays);
    int e_od;
    int e_ps;
    e_od = cl ? 2 : 2 + int'($signed(od));
    e_ps = 3 + int'($signed(ps));
    if (e_od < 0)
      e_od = 0;
    if (e_ps < 0)
      e_ps = 0;
    xfer(1'b1, hsq_pkg::IDX_MAIN_REP, {29'h0, main});
    xfer(1'b1, hsq_pkg::IDX_OD_ADJ, {24'h0, od});
    xfer(1'b1, hsq_pkg::IDX_PS_ADJ, {24'h0, ps});
    od_cnt = 0;
    ps_cnt = 0;
    ng_cnt = 0;
    xfer(1'b1, hsq_pkg::IDX_CTRL, {30'h0, cl, 1'b1});
    repeat (2) @(posedge ref_clk_in);
    chk({31'h0, busy}, 32'h1, "busy after go");
    wait_idle(8000);
    chk(32'(od_cnt), 32'(plays * e_od), "overdrive cycles");
    chk(32'(ps_cnt), 32'(plays * e_ps), "sustain cycles");
    chk(32'(ng_cnt), 32'(plays * 2), "negative cycles");
  endtask

  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    xfer(1'b0, hsq_pkg::IDX_MAIN_REP, 32'h0);
    chk(rd, 32'h0, "main repeat reset");
    xfer(1'b0, hsq_pkg::IDX_OD_ADJ, 32'h0);
    chk(rd, 32'h0, "overdrive adjust reset");
    xfer(1'b0, hsq_pkg::IDX_PS_ADJ, 32'h0);
    chk(rd, 32'h0, "sustain adjust reset");
    xfer(1'b0, hsq_pkg::IDX_TICK, 32'h0);
    chk(rd, {24'h0, hsq_pkg::RST_TICK}, "tick period reset");
    xfer(1'b1, hsq_pkg::IDX_MAIN_REP, 32'hffff_ffff);
    xfer(1'b0, hsq_pkg::IDX_MAIN_REP, 32'h0);
    chk(rd, 32'h7, "main repeat width");
    xfer(1'b1, hsq_pkg::IDX_OD_ADJ, 32'h5a);
    xfer(1'b0, hsq_pkg::IDX_OD_ADJ, 32'h0);
    chk(rd, 32'h5a, "overdrive adjust rw");
    xfer(1'b1, hsq_pkg::IDX_PS_ADJ, 32'ha5);
    xfer(1'b0, hsq_pkg::IDX_PS_ADJ, 32'h0);
    chk(rd, 32'ha5, "sustain adjust rw");
    xfer(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    // two slots, slot zero played twice, pass ends at the zero third slot
    xfer(1'b1, hsq_pkg::IDX_TICK, 32'h0);
    xfer(1'b1, hsq_pkg::IDX_SLOT_ID, 32'h1);
    xfer(1'b1, hsq_pkg::IDX_SLOT_ID + 8'h1, 32'h2);
    xfer(1'b1, hsq_pkg::IDX_SLOT_REP_LO, 32'h1);
    for (int i = 0; i < 7; i++)
      play(3'(i), t_od[i], t_ps[i], i == 4, (i + 1) * 3);
    // tick period one makes every unit two clocks, so plays is doubled
    xfer(1'b1, hsq_pkg::IDX_TICK, 32'h1);
    play(3'h0, 8'h01, 8'hff, 1'b0, 6);
    xfer(1'b1, hsq_pkg::IDX_TICK, 32'h0);
    // all eight slots in use, last slot played four times
    for (int k = 2; k < 8; k++)
      xfer(1'b1, hsq_pkg::IDX_SLOT_ID + 8'(k), 32'(k + 1));
    xfer(1'b1, hsq_pkg::IDX_SLOT_REP_HI, 32'hc0);
    play(3'h0, 8'h00, 8'h00, 1'b0, 12);
    // endless loop stopped by trigger, restarted by trigger, halted by go
    xfer(1'b1, hsq_pkg::IDX_MAIN_REP, 32'h7);
    xfer(1'b1, hsq_pkg::IDX_CTRL, 32'h1);
    repeat (600) @(posedge ref_clk_in);
    chk({31'h0, busy}, 32'h1, "endless still busy");
    xfer(1'b0, hsq_pkg::IDX_CTRL, 32'h0);
    chk(rd, 32'h1, "go reads back busy");
    pulse_trig;
    wait_idle(20);
    repeat (4) @(posedge ref_clk_in);
    pulse_trig;
    repeat (8) @(posedge ref_clk_in);
    chk({31'h0, busy}, 32'h1, "trigger start");
    xfer(1'b1, hsq_pkg::IDX_CTRL, 32'h0);
    wait_idle(4);
    test_done;
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (60000) @(posedge ref_clk_in);
    failures++;
    $display("mismatch at %0t: run did not finish in time", $time);
    test_done;
  end
endmodule
`default_nettype wire
